// ---- pkg/ethmac_params.svh ----
`ifndef ETHMAC_PARAMS_SVH
`define ETHMAC_PARAMS_SVH
// Frame layout
`define ETHMAC_PRE_BYTES 11'h007
`define ETHMAC_PRE_BYTE 8'h55
`define ETHMAC_SFD_BYTE 8'hD5
`define ETHMAC_MIN_NOFCS 11'h03C
`define ETHMAC_FCS_BYTES 11'h004
`define ETHMAC_MIN_FRAME 11'h040
`define ETHMAC_MAX_FRAME 11'h5EE
`define ETHMAC_DA_LAST 11'h005
`define ETHMAC_LT_HI 11'h00C
`define ETHMAC_LT_LO 11'h00D
`define ETHMAC_MAX_LEN 16'h05DC
`define ETHMAC_MIN_TYPE 16'h0600
// Check sequence, bit-reversed form
`define ETHMAC_CRC_INIT 32'hFFFF_FFFF
`define ETHMAC_CRC_POLY 32'hEDB8_8320
`define ETHMAC_CRC_RESIDUE 32'hDEBB_20E3
// Timing counts: gap in link steps, slow divider in reference edges; FIFO depth in entries
`define ETHMAC_GAP_NIBBLES 7'h18
`define ETHMAC_GAP_DIBITS 7'h30
`define ETHMAC_SLOW_DIV 4'h9
`define ETHMAC_FIFO_DEPTH 32
`endif

// ---- pkg/ethmac_pkg.sv ----
`default_nettype none
package ethmac_pkg;
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } ethmac_byte_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PRE = 3'b001,
        TX_SFD = 3'b010,
        TX_DATA = 3'b011,
        TX_PAD = 3'b100,
        TX_FCS = 3'b101,
        TX_GAP = 3'b110
    } ethmac_tx_state_t;
    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_BODY = 2'b01,
        RX_WAIT = 2'b10
    } ethmac_rx_state_t;
endpackage
`default_nettype wire

// ---- hw/ethmac_top.sv ----
`include "ethmac_params.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Transmit byte FIFO
module ethmac_fifo import ethmac_pkg::*; #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `ETHMAC_FIFO_DEPTH
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    assign out_valid_out = count != '0;
    assign out_data_out = mem[rd_ptr];

    // Storage and pointers
    always_ff @(posedge clock_in) begin
        if (ce_in && push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_out <= 1'b0;
        end else if (ce_in) begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= (AW+1)'(count + push - pop);
            in_ready_out <= (AW+1)'(count + push - pop) != (AW+1)'(DEPTH);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ethmac_top import ethmac_pkg::*; #(
    parameter int FIFO_DEPTH = `ETHMAC_FIFO_DEPTH
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic rmii_select_in,
    input wire logic speed_100_in,
    input wire logic [47:0] station_address_in,
    input wire logic [63:0] hash_filter_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_last_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic tx_or_reference_clock_pin,
    input wire logic receive_clock_in,
    input wire logic carrier_or_carrier_valid_pin,
    input wire logic receive_valid_in,
    input wire logic [3:0] receive_data_bus,
    input wire logic receive_error_in,
    input wire logic collision_detect_in,
    output logic [3:0] transmit_data_bus,
    output logic transmit_enable_out,
    output logic transmit_error_out,
    output logic tx_collision_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic rx_last_out,
    output logic rx_ok_out,
    output logic rx_is_length_out,
    output logic rx_is_type_out
);
    logic [9:0] pin_s1;
    logic [9:0] pin_s2;
    logic [1:0] clk_s3;
    logic txc_rise;
    logic rxc_rise;
    logic slow_ok;
    logic [3:0] slow_cnt;
    logic tx_step;
    logic rx_step;
    ethmac_byte_t fifo_in;
    ethmac_byte_t fifo_out;
    logic fifo_valid;
    logic pop;
    ethmac_tx_state_t tx_state;
    logic [7:0] tx_sh;
    logic [2:0] tx_pos;
    logic [10:0] tx_cnt;
    logic [31:0] tx_crc;
    logic [23:0] tx_fcs;
    logic tx_cur_last;
    logic tx_end;
    logic tx_need;
    ethmac_rx_state_t rx_state;
    logic rx_dv;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic [2:0] rx_pos;
    logic rx_done;
    logic [10:0] rx_bcnt;
    logic [31:0] rx_crc;
    logic [31:0] next_rx_crc;
    logic [47:0] rx_da;
    logic [47:0] next_da;
    logic [15:0] rx_lt;
    logic [7:0] rx_pend;
    logic rx_have;
    logic rx_err;
    logic rx_accept;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `ETHMAC_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; bit 9 tx/ref clock, bit 8 rx clock
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            clk_s3 <= '0;
        end else if (ce_in) begin
            pin_s1 <= {tx_or_reference_clock_pin, receive_clock_in, carrier_or_carrier_valid_pin,
                       receive_valid_in, receive_data_bus, receive_error_in, collision_detect_in};
            pin_s2 <= pin_s1;
            clk_s3 <= pin_s2[9:8];
        end
    end

    // Link clock edges; reduced mode takes both directions from the shared pin
    assign txc_rise = pin_s2[9] & ~clk_s3[1];
    assign rxc_rise = rmii_select_in ? txc_rise : (pin_s2[8] & ~clk_s3[0]);
    assign rx_dv = rmii_select_in ? pin_s2[7] : pin_s2[6];

    // Reduced mode at 10 Mb/s repeats each dibit over ten reference edges
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slow_cnt <= '0;
        end else if (ce_in && txc_rise) begin
            slow_cnt <= (slow_cnt == `ETHMAC_SLOW_DIV) ? 4'h0 : 4'(slow_cnt + 1'b1);
        end
    end
    assign slow_ok = speed_100_in | ~rmii_select_in | (slow_cnt == 4'h0);
    assign tx_step = txc_rise & slow_ok;
    assign rx_step = rxc_rise & slow_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path
    assign fifo_in = '{last: tx_last_in, data: tx_data_in};

    ethmac_fifo #(.WIDTH($bits(ethmac_byte_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .in_data_in(fifo_in),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .out_data_out(fifo_out),
        .out_valid_out(fifo_valid),
        .out_ready_in(pop)
    );

    // Last chunk of the byte in the shifter; a frame byte is taken from the FIFO
    assign tx_end = rmii_select_in ? (tx_pos == 3'h6) : (tx_pos == 3'h4);
    assign tx_need = (tx_state == TX_SFD) | ((tx_state == TX_DATA) & ~tx_cur_last);
    assign pop = ce_in & tx_step & tx_end & tx_need & fifo_valid;

    // Frame assembly, one link step per nibble or dibit
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_state <= TX_IDLE;
            tx_sh <= '0;
            tx_pos <= '0;
            tx_cnt <= '0;
            tx_crc <= `ETHMAC_CRC_INIT;
            tx_fcs <= '0;
            tx_cur_last <= 1'b0;
            transmit_data_bus <= '0;
            transmit_enable_out <= 1'b0;
            transmit_error_out <= 1'b0;
        end else if (ce_in && tx_step) begin
            transmit_error_out <= 1'b0;
            case (tx_state)
                TX_IDLE: begin
                    transmit_enable_out <= 1'b0;
                    transmit_data_bus <= '0;
                    if (fifo_valid) begin
                        tx_state <= TX_PRE;
                        tx_sh <= `ETHMAC_PRE_BYTE;
                        tx_pos <= '0;
                        tx_cnt <= 11'h001;
                        tx_crc <= `ETHMAC_CRC_INIT;
                    end
                end
                TX_GAP: begin
                    transmit_enable_out <= 1'b0;
                    transmit_data_bus <= '0;
                    tx_cnt <= 11'(tx_cnt + 1'b1);
                    if (tx_cnt[6:0] == 7'(((rmii_select_in ? `ETHMAC_GAP_DIBITS : `ETHMAC_GAP_NIBBLES) - 1'b1))) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: begin
                    transmit_enable_out <= 1'b1;
                    transmit_data_bus <= rmii_select_in ? {2'b00, tx_sh[1:0]} : tx_sh[3:0];
                    tx_sh <= rmii_select_in ? (tx_sh >> 2) : (tx_sh >> 4);
                    tx_pos <= 3'(tx_pos + (rmii_select_in ? 3'h2 : 3'h4));
                    if (tx_end) begin
                        tx_pos <= '0;
                        case (tx_state)
                            TX_PRE: begin
                                tx_cnt <= 11'(tx_cnt + 1'b1);
                                if (tx_cnt == `ETHMAC_PRE_BYTES) begin
                                    tx_state <= TX_SFD;
                                    tx_sh <= `ETHMAC_SFD_BYTE;
                                    tx_cnt <= '0;
                                end else begin
                                    tx_sh <= `ETHMAC_PRE_BYTE;
                                end
                            end
                            TX_FCS: begin
                                tx_cnt <= 11'(tx_cnt + 1'b1);
                                tx_sh <= tx_fcs[7:0];
                                tx_fcs <= tx_fcs >> 8;
                                if (tx_cnt == `ETHMAC_FCS_BYTES) begin
                                    tx_state <= TX_GAP;
                                    tx_cnt <= '0;
                                end
                            end
                            default: begin
                                if (tx_need && fifo_valid) begin
                                    tx_state <= TX_DATA;
                                    tx_sh <= fifo_out.data;
                                    tx_cur_last <= fifo_out.last;
                                    tx_crc <= crc_byte(tx_crc, fifo_out.data);
                                    tx_cnt <= 11'(tx_cnt + 1'b1);
                                end else if (tx_need) begin
                                    // Underrun aborts the frame, flagged only in full mode
                                    transmit_error_out <= ~rmii_select_in;
                                    tx_state <= TX_GAP;
                                    tx_cnt <= '0;
                                end else if (tx_cnt < `ETHMAC_MIN_NOFCS) begin
                                    tx_state <= TX_PAD;
                                    tx_sh <= 8'h00;
                                    tx_crc <= crc_byte(tx_crc, 8'h00);
                                    tx_cnt <= 11'(tx_cnt + 1'b1);
                                end else begin
                                    tx_state <= TX_FCS;
                                    tx_sh <= ~tx_crc[7:0];
                                    tx_fcs <= ~tx_crc[31:8];
                                    tx_cnt <= 11'h001;
                                    tx_cur_last <= 1'b0;
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // Collision report, full mode only
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_collision_out <= 1'b0;
        end else if (ce_in) begin
            tx_collision_out <= pin_s2[0] & transmit_enable_out & ~rmii_select_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive path
    assign rx_byte = rmii_select_in ? {pin_s2[3:2], rx_sh[7:2]} : {pin_s2[5:2], rx_sh[7:4]};
    assign rx_done = rmii_select_in ? (rx_pos == 3'h6) : (rx_pos == 3'h4);
    assign next_rx_crc = crc_byte(rx_crc, rx_byte);
    assign next_da = {rx_byte, rx_da[47:8]};

    // Delimiter hunt, byte assembly and one-byte delay to mark the last byte
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_state <= RX_HUNT;
            rx_sh <= '0;
            rx_pos <= '0;
            rx_bcnt <= '0;
            rx_crc <= `ETHMAC_CRC_INIT;
            rx_da <= '0;
            rx_lt <= '0;
            rx_pend <= '0;
            rx_have <= 1'b0;
            rx_err <= 1'b0;
            rx_accept <= 1'b0;
            rx_data_out <= '0;
            rx_valid_out <= 1'b0;
            rx_last_out <= 1'b0;
            rx_ok_out <= 1'b0;
            rx_is_length_out <= 1'b0;
            rx_is_type_out <= 1'b0;
        end else if (ce_in) begin
            rx_valid_out <= 1'b0;
            if (rx_step) begin
                case (rx_state)
                    RX_HUNT: begin
                        rx_pos <= '0;
                        rx_bcnt <= '0;
                        rx_crc <= `ETHMAC_CRC_INIT;
                        rx_have <= 1'b0;
                        rx_err <= 1'b0;
                        if (rx_dv && (rmii_select_in ? (pin_s2[3:2] == 2'b11) : (pin_s2[5:2] == 4'hD))) begin
                            rx_state <= RX_BODY;
                        end
                    end
                    RX_BODY: begin
                        if (rx_dv) begin
                            rx_sh <= rx_byte;
                            rx_pos <= 3'(rx_pos + (rmii_select_in ? 3'h2 : 3'h4));
                            rx_err <= rx_err | pin_s2[1];
                            if (rx_done) begin
                                rx_pos <= '0;
                                rx_pend <= rx_byte;
                                rx_have <= 1'b1;
                                rx_valid_out <= rx_have;
                                rx_data_out <= rx_pend;
                                rx_last_out <= 1'b0;
                                rx_ok_out <= 1'b0;
                                rx_crc <= next_rx_crc;
                                rx_bcnt <= (rx_bcnt == 11'h7FF) ? rx_bcnt : 11'(rx_bcnt + 1'b1);
                                if (rx_bcnt <= `ETHMAC_DA_LAST) begin
                                    rx_da <= next_da;
                                end
                                if (rx_bcnt == `ETHMAC_DA_LAST) begin
                                    rx_accept <= (&next_da)
                                        | (next_da[0] & hash_filter_in[next_rx_crc[31:26]])
                                        | (~next_da[0] & (next_da == station_address_in));
                                end
                                if (rx_bcnt == `ETHMAC_LT_HI || rx_bcnt == `ETHMAC_LT_LO) begin
                                    rx_lt <= {rx_lt[7:0], rx_byte};
                                end
                            end
                        end else begin
                            // End of carrier closes the frame
                            rx_state <= RX_HUNT;
                            rx_valid_out <= rx_have;
                            rx_data_out <= rx_pend;
                            rx_last_out <= 1'b1;
                            rx_ok_out <= rx_have & rx_accept & ~rx_err & (rx_pos == 3'h0)
                                & (rx_crc == `ETHMAC_CRC_RESIDUE)
                                & (rx_bcnt >= `ETHMAC_MIN_FRAME) & (rx_bcnt <= `ETHMAC_MAX_FRAME);
                            rx_is_length_out <= rx_lt <= `ETHMAC_MAX_LEN;
                            rx_is_type_out <= rx_lt >= `ETHMAC_MIN_TYPE;
                        end
                    end
                    default: begin
                        rx_state <= RX_HUNT;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    chk_rmii_no_txer: assert property (rmii_select_in && $past(rmii_select_in) |-> !transmit_error_out)
        else $error("transmit error driven in reduced mode");
    chk_rmii_high_bits: assert property (rmii_select_in && $past(rmii_select_in) |-> transmit_data_bus[3:2] == 2'b00)
        else $error("upper data bits driven in reduced mode");
    chk_sfd_after_pre: assert property ($rose(tx_state == TX_SFD) |-> tx_sh == `ETHMAC_SFD_BYTE && $past(tx_state) == TX_PRE)
        else $error("delimiter not loaded after preamble");
    chk_pad_minimum: assert property ($rose(tx_state == TX_FCS) |-> $past(tx_cnt) >= `ETHMAC_MIN_NOFCS)
        else $error("check field started before minimum length");
    chk_fcs_four: assert property ($rose(tx_state == TX_GAP) && $past(tx_state) == TX_FCS |-> $past(tx_cnt) == 11'h004)
        else $error("check field not four bytes");
    chk_idle_quiet: assert property (tx_state == TX_IDLE && tx_step && ce_in |=> !transmit_enable_out)
        else $error("transmit enable high while idle");
    chk_rx_residue: assert property (rx_ok_out && $rose(rx_last_out) |-> $past(rx_crc) == `ETHMAC_CRC_RESIDUE)
        else $error("frame accepted with bad check residue");
    chk_rx_length: assert property (rx_ok_out && $rose(rx_last_out) |-> $past(rx_bcnt) >= `ETHMAC_MIN_FRAME && $past(rx_bcnt) <= `ETHMAC_MAX_FRAME)
        else $error("frame accepted outside length limits");
endmodule
`default_nettype wire

// ---- testbench/ethmac_phy_model.sv ----
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Transceiver model: link clocks, transmit capture, receive frames
module ethmac_phy_model (
    input wire logic rmii_in,
    input wire logic [3:0] tx_data_in,
    input wire logic tx_en_in,
    output logic tx_clock_out,
    output logic rx_clock_out,
    output logic rx_dv_out,
    output logic [3:0] rx_data_out,
    output logic rx_err_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] tx_q[$];
    // Link clocks of 80 ns with unrelated phase
    initial begin
        tx_clock_out = 1'b0;
        forever #40 tx_clock_out = ~tx_clock_out;
    end
    initial begin
        rx_clock_out = 1'b0;
        rx_dv_out = 1'b0;
        rx_data_out = 4'h0;
        rx_err_out = 1'b0;
        #13;
        forever #40 rx_clock_out = ~rx_clock_out;
    end
    // Record the bus at every transmit clock rise while transmit enable is high
    always @(posedge tx_clock_out) begin
        if (tx_en_in === 1'b1) begin
            tx_q.push_back(rmii_in ? {2'b00, tx_data_in[1:0]} : tx_data_in);
        end
    end
    // Preamble, delimiter, frame, low unit first; data flips once released
    task automatic send(input logic [7:0] f[$]);
        logic [7:0] b;
        int w;
        w = rmii_in ? 2 : 4;
        for (int i = -8; i < f.size(); i++) begin
            b = (i < -1) ? 8'h55 : (i == -1) ? 8'hD5 : f[i];
            for (int k = 0; k < 8; k += w) begin
                if (rmii_in) @(negedge tx_clock_out); else @(negedge rx_clock_out);
                rx_dv_out = 1'b1;
                rx_data_out = (w == 2) ? {2'b00, b[k +: 2]} : b[k +: 4];
            end
        end
        if (rmii_in) @(negedge tx_clock_out); else @(negedge rx_clock_out);
        rx_dv_out = 1'b0;
        rx_data_out = ~rx_data_out;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_ethmac_top.sv ----
`include "ethmac_params.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Bench for the framing block against a transceiver model
module tb_ethmac_top import ethmac_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in, rst_b_in, rmii, spd, col, txv, txl, tx_bad, r_ok, r_len, r_typ, r_done;
    logic [7:0] txd;
    logic [63:0] hash;
    logic [47:0] station;
    logic [7:0] rx_q[$];
    int errors, checks_done;
    wire logic txck, rxck, dv, rerr, txr, txen, txer, txcol, rv, rl, rok, rlen, rtyp;
    wire logic [3:0] rxd, txbus;
    wire logic [7:0] rdat;
    ethmac_top #(.FIFO_DEPTH(4)) dut_u (.clock_in(clock_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
        .rmii_select_in(rmii), .speed_100_in(spd), .station_address_in(station), .hash_filter_in(hash),
        .tx_data_in(txd), .tx_last_in(txl), .tx_valid_in(txv), .tx_ready_out(txr),
        .tx_or_reference_clock_pin(txck), .receive_clock_in(rxck), .carrier_or_carrier_valid_pin(dv),
        .receive_valid_in(dv), .receive_data_bus(rxd), .receive_error_in(rerr), .collision_detect_in(col),
        .transmit_data_bus(txbus), .transmit_enable_out(txen), .transmit_error_out(txer),
        .tx_collision_out(txcol), .rx_data_out(rdat), .rx_valid_out(rv), .rx_last_out(rl),
        .rx_ok_out(rok), .rx_is_length_out(rlen), .rx_is_type_out(rtyp));
    ethmac_phy_model phy_u (.rmii_in(rmii), .tx_data_in(txbus), .tx_en_in(txen), .tx_clock_out(txck),
        .rx_clock_out(rxck), .rx_dv_out(dv), .rx_data_out(rxd), .rx_err_out(rerr));
    // System clock, 10 ns
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // Collect received bytes and watch transmit error lines
    always @(negedge clock_in) begin
        if (rv === 1'b1) begin
            rx_q.push_back(rdat);
            if (rl === 1'b1) begin
                r_ok = rok;
                r_len = rlen;
                r_typ = rtyp;
                r_done = 1'b1;
            end
        end
        if (txer === 1'b1 || txcol === 1'b1) tx_bad = 1'b1;
    end
    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic give_up();
        errors++;
        report_and_stop();
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Reflected check sequence, appended low byte first
    task automatic add_fcs(ref logic [7:0] f[$], input logic bad);
        logic [31:0] c;
        c = `ETHMAC_CRC_INIT;
        foreach (f[i]) begin
            for (int k = 0; k < 8; k++) c = (c[0] ^ f[i][k]) ? (c >> 1) ^ `ETHMAC_CRC_POLY : c >> 1;
        end
        c = ~c ^ (bad ? 32'h0000_0001 : 32'h0000_0000);
        for (int i = 0; i < 4; i++) f.push_back(c[8 * i +: 8]);
    endtask
    // Offer one byte, held until the FIFO takes it
    task automatic push(input logic [8:0] v);
        int n = 0;
        while (txr !== 1'b1) begin
            @(negedge clock_in);
            n++;
            if (n > 5000) give_up();
        end
        {txl, txd} = v;
        txv = 1'b1;
        @(negedge clock_in);
    endtask
    // Short frame out; preamble, delimiter, pad and check field on the wire
    task automatic tx_case(input logic rm, input logic sp);
        logic [7:0] f[$], e[$], b;
        int n, w, rep;
        rmii = rm;
        spd = sp;
        col = rm;
        tx_bad = 1'b0;
        phy_u.tx_q.delete();
        w = rm ? 2 : 4;
        rep = (rm && !sp) ? 10 : 1;
        for (int i = 0; i < 18; i++) f.push_back(8'(i * 7 + 1));
        for (int i = 0; i < 18; i++) push({i == 17, f[i]});
        txv = 1'b0;
        n = 0;
        while (txen !== 1'b0 && n < 40000) begin
            @(negedge clock_in);
            n++;
        end
        if (n >= 40000) give_up();
        repeat (80 * rep * 8) @(negedge clock_in);
        repeat (7) e.push_back(8'h55);
        e.push_back(8'hD5);
        while (f.size() < 60) f.push_back(8'h00);
        add_fcs(f, 1'b0);
        e = {e, f};
        cmp(32'(phy_u.tx_q.size()), 32'(e.size() * 8 / w * rep));
        foreach (e[i]) begin
            b = 8'h00;
            for (int k = 0; k < 8 / w; k++) b = b | (8'(phy_u.tx_q[(i * 8 / w + k) * rep]) << (k * w));
            cmp(32'(b), 32'(e[i]));
        end
        cmp(32'(tx_bad), 32'h0000_0000);
    endtask
    // One frame in; bytes, verdict and length or type judged
    task automatic rx_case(input logic [47:0] da, input logic [15:0] lt, input int nd, input logic bad,
        input logic ok);
        logic [7:0] f[$];
        int n = 0;
        for (int i = 0; i < 6; i++) f.push_back(da[8 * i +: 8]);
        for (int i = 0; i < 6; i++) f.push_back(8'(8'h20 + i));
        f.push_back(lt[15:8]);
        f.push_back(lt[7:0]);
        for (int i = 0; i < nd; i++) f.push_back(8'(i));
        add_fcs(f, bad);
        rx_q.delete();
        r_done = 1'b0;
        phy_u.send(f);
        while (r_done !== 1'b1) begin
            @(negedge clock_in);
            n++;
            if (n > 300) give_up();
        end
        cmp(32'(rx_q.size()), 32'(f.size()));
        foreach (f[i]) cmp(32'(rx_q[i]), 32'(f[i]));
        cmp(32'(r_ok), 32'(ok));
        cmp(32'(r_len), 32'(lt <= 16'h05DC));
        cmp(32'(r_typ), 32'(lt >= 16'h0600));
    endtask
    // Main sequence
    initial begin
        errors = 0;
        checks_done = 0;
        rst_b_in = 1'b0;
        {rmii, spd, col, txv, txl, tx_bad, r_done} = 7'h00;
        txd = 8'h00;
        hash = 64'hFFFF_FFFF_FFFF_FFFF;
        station = 48'h5544_3322_1100;
        repeat (3) @(negedge clock_in);
        rst_b_in = 1'b1;
        repeat (2) @(negedge clock_in);
        tx_case(1'b0, 1'b1);
        tx_case(1'b1, 1'b1);
        tx_case(1'b1, 1'b0);
        {rmii, spd, col} = 3'h1;
        rx_case(48'hFFFF_FFFF_FFFF, 16'h0800, 46, 1'b0, 1'b1);
        rx_case(station, 16'h002E, 46, 1'b0, 1'b1);
        rx_case(48'h5544_3322_1102, 16'h05DC, 46, 1'b0, 1'b0);
        rx_case(48'h0000_0000_0001, 16'h0600, 46, 1'b0, 1'b1);
        hash = 64'h0000_0000_0000_0000;
        rx_case(48'h0000_0000_0001, 16'h0600, 46, 1'b0, 1'b0);
        rx_case(48'hFFFF_FFFF_FFFF, 16'h0800, 46, 1'b1, 1'b0);
        rx_case(48'hFFFF_FFFF_FFFF, 16'h002D, 45, 1'b0, 1'b0);
        {rmii, spd} = 2'b11;
        rx_case(48'hFFFF_FFFF_FFFF, 16'h0800, 50, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
